// ### rtl/dcbs_defines.vh
/*
  constants for the dc-balanced 21-bit serializer: lane geometry, framing
  lengths, forwarded clock patterns, running-sum encoding and lock count.
  assumes it is included by bare name from the serializer design file.
*/
`ifndef DCBS_DEFINES_VH
`define DCBS_DEFINES_VH

// lane geometry
`define DCBS_LANES 3
`define DCBS_PAY_BITS 7
`define DCBS_FRAME_BITS 9
`define DCBS_DATA_BITS 21

// index of the last bit of a frame, per framing
`define DCBS_LAST_PLAIN 4'h6
`define DCBS_LAST_BAL 4'h8
`define DCBS_BITCNT_ZERO 4'h0
`define DCBS_BITCNT_ONE 4'h1

// forwarded clock shapes, sent lsb first
`define DCBS_CLK_PLAIN 9'h00F
`define DCBS_CLK_BAL_SHORT 9'h00F
`define DCBS_CLK_BAL_LONG 9'h01F
`define DCBS_CLK_IDLE 9'h000

// running sum, five-bit two's complement
`define DCBS_RS_ZERO 5'h00
`define DCBS_DISP_OFFSET 5'h07

// pll lock bound in parallel clock periods
`define DCBS_LOCK_PERIODS 32800
`define DCBS_LOCK_W 16

// buffer depth in words
`define DCBS_FIFO_DEPTH 32

`endif

// ### rtl/dcbs_serializer.v
/*
  21-bit to 3-lane serializer with forwarded clock, plain 7-bit framing or
  dc-balanced 9-bit framing, a word buffer and a power-down/lock sequence.
  holds the buffer, the per-lane encoder and the top module dcbs_serializer.
  assumes ref_clk_in is the only clock; parallel clock, data and control pins
  arrive asynchronously and are sampled; one serial bit leaves per ref clock.
*/
`timescale 1ns/100ps
`include "dcbs_defines.vh"

// word buffer between the parallel capture and the serializer
module dcbs_fifo #(
  parameter WIDTH = 22,
  parameter DEPTH = `DCBS_FIFO_DEPTH,
  parameter AW = 5
) (
  input wire clk_in,
  input wire rst_in,
  input wire clear_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // flip-flop storage
  reg [AW-1:0] wr_ptr_r; // next slot to write
  reg [AW-1:0] rd_ptr_r; // oldest word
  reg [AW:0] count_r; // words held, one bit wider than the pointers
  wire push;
  wire pop;

  assign in_ready_out = (count_r != DEPTH[AW:0]);
  assign out_valid_out = (count_r != {(AW+1){1'b0}});
  assign out_data_out = mem_r[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // pointers and fill count; clear empties the buffer without touching data
  always @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // storage write; no reset needed, the count guards stale words
  always @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end
endmodule

// one data lane: inversion choice, flag append and shift-out
module dcbs_lane (
  input wire clk_in,
  input wire rst_in,
  input wire clear_in,
  input wire load_in,
  input wire shift_in,
  input wire balance_in,
  input wire [`DCBS_PAY_BITS-1:0] group_in,
  output wire bit_out
);
  reg [`DCBS_FRAME_BITS-1:0] sh_r; // frame being shifted, lsb leaves first
  reg [4:0] rs_r; // running digital sum of this lane
  reg [2:0] ones; // ones in the incoming group
  reg [4:0] disp; // ones minus zeros of the group
  reg sum_pos; // running sum above zero
  reg sum_neg; // running sum below zero
  reg inv; // send this group inverted
  reg [`DCBS_PAY_BITS-1:0] payload; // group as it goes on the wire
  integer i;

  assign bit_out = sh_r[0];

  // disparity and inversion choice for the group now offered
  always @* begin
    ones = 3'h0;
    for (i = 0; i < `DCBS_PAY_BITS; i = i + 1) begin
      ones = ones + {2'h0, group_in[i]};
    end
    disp = {1'b0, ones, 1'b0} - `DCBS_DISP_OFFSET;
    sum_neg = rs_r[4];
    sum_pos = !rs_r[4] && (rs_r != `DCBS_RS_ZERO);
    // a zero sum never inverts; matching signs do
    inv = balance_in && ((sum_pos && !disp[4]) || (sum_neg && disp[4]));
    payload = inv ? ~group_in : group_in;
  end

  // load a frame at the word boundary, otherwise shift one bit per clock
  always @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      sh_r <= {`DCBS_FRAME_BITS{1'b0}};
      rs_r <= `DCBS_RS_ZERO; // every relock starts balanced
    end else if (load_in) begin
      if (balance_in) begin
        // payload then flags: 1,0 inverted, 0,1 plain
        sh_r <= {~inv, inv, payload};
        // flags are net zero, so only the sent payload moves the sum
        rs_r <= inv ? rs_r - disp : rs_r + disp;
      end else begin
        // plain framing: raw seven bits, no tracking
        sh_r <= {2'b00, group_in};
      end
    end else if (shift_in) begin
      sh_r <= {1'b0, sh_r[`DCBS_FRAME_BITS-1:1]};
    end
  end
endmodule

// top: capture, buffer, lock sequencing and serial output
module dcbs_serializer #(
  parameter LOCK_PERIODS = `DCBS_LOCK_PERIODS, // shorten for simulation
  parameter FIFO_DEPTH = `DCBS_FIFO_DEPTH,
  parameter FIFO_AW = 5
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire parallel_clock_in,
  input wire [`DCBS_DATA_BITS-1:0] parallel_data_in,
  input wire power_down_n_in,
  input wire balance_mode_select_in,
  output wire [`DCBS_LANES-1:0] serial_lane_out,
  output reg serial_lane_oe_out,
  output wire forwarded_clock_out,
  output reg forwarded_clock_oe_out,
  output wire serial_valid_out,
  output reg frame_start_out,
  output reg pll_run_out,
  output reg term_enable_out,
  output reg term_high_out,
  output reg locked_out,
  output reg overflow_out,
  output reg fifo_ready_out
);
  localparam WW = `DCBS_DATA_BITS + 1; // buffered word: mode bit over data

  // two-stage samplers for every asynchronous pin
  reg [`DCBS_DATA_BITS-1:0] data_s1_r;
  reg [`DCBS_DATA_BITS-1:0] data_s2_r;
  reg pclk_s1_r;
  reg pclk_s2_r;
  reg pclk_s3_r; // previous sampled level, for edge finding
  reg pwr_s1_r;
  reg pwr_s2_r;
  reg mode_s1_r;
  reg mode_s2_r;

  reg [`DCBS_LOCK_W-1:0] lock_cnt_r; // parallel periods since release
  reg locked_r;
  reg busy_r; // a frame is on the wire
  reg [3:0] bcnt_r; // bit index inside the frame
  reg frame_bal_r; // framing of the frame on the wire
  reg clk_long_r; // next balanced clock frame is the 5/9 one
  reg [`DCBS_FRAME_BITS-1:0] ck_sh_r; // forwarded clock pattern

  wire pclk_rise;
  wire powered;
  wire bit_last;
  wire load;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WW-1:0] fifo_out_data;
  wire push_req;
  wire word_bal;
  wire [`DCBS_LANES-1:0] lane_bits;

  assign pclk_rise = pclk_s2_r & ~pclk_s3_r;
  assign powered = pwr_s2_r;
  // words are taken only once locked, so lock-time garbage never reaches the link
  assign push_req = pclk_rise & locked_r & powered;
  assign word_bal = fifo_out_data[WW-1];
  assign bit_last = busy_r && (bcnt_r == (frame_bal_r ? `DCBS_LAST_BAL : `DCBS_LAST_PLAIN));
  // next frame starts straight after the last bit, so frames run back to back
  assign load = fifo_out_valid && locked_r && powered && (!busy_r || bit_last);
  assign serial_lane_out = lane_bits;
  assign forwarded_clock_out = ck_sh_r[0];
  assign serial_valid_out = busy_r;

  // pin samplers; pins pulled by the package default as noted
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      data_s1_r <= {`DCBS_DATA_BITS{1'b0}};
      data_s2_r <= {`DCBS_DATA_BITS{1'b0}};
      pclk_s1_r <= 1'b0;
      pclk_s2_r <= 1'b0;
      pclk_s3_r <= 1'b0;
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
      mode_s1_r <= 1'b1;
      mode_s2_r <= 1'b1;
    end else begin
      data_s1_r <= parallel_data_in;
      data_s2_r <= data_s1_r;
      pclk_s1_r <= parallel_clock_in;
      pclk_s2_r <= pclk_s1_r;
      pclk_s3_r <= pclk_s2_r;
      pwr_s1_r <= power_down_n_in;
      pwr_s2_r <= pwr_s1_r;
      mode_s1_r <= balance_mode_select_in;
      mode_s2_r <= mode_s1_r;
    end
  end

  // lock counter: counts parallel periods after release, cleared by power-down
  always @(posedge ref_clk_in) begin
    if (rst_in || !powered) begin
      lock_cnt_r <= {`DCBS_LOCK_W{1'b0}};
      locked_r <= 1'b0; // outputs stay floating while down
    end else if (!locked_r && pclk_rise) begin
      // a stalled parallel clock stalls the lock as well
      if (lock_cnt_r == LOCK_PERIODS[`DCBS_LOCK_W-1:0] - 1'b1) begin
        locked_r <= 1'b1; // enabled on the last counted period
      end else begin
        lock_cnt_r <= lock_cnt_r + 1'b1;
      end
    end
  end

  // pin controls: pll, termination, output enables, buffer status
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pll_run_out <= 1'b0;
      term_enable_out <= 1'b0;
      term_high_out <= 1'b0;
      serial_lane_oe_out <= 1'b0;
      forwarded_clock_oe_out <= 1'b0;
      locked_out <= 1'b0;
      fifo_ready_out <= 1'b0;
    end else begin
      pll_run_out <= powered;
      term_enable_out <= powered; // termination back in from release
      // plain framing uses the 410 ohm setting
      term_high_out <= powered & ~mode_s2_r;
      // drive only once locked
      serial_lane_oe_out <= powered & locked_r;
      forwarded_clock_oe_out <= powered & locked_r;
      locked_out <= locked_r;
      fifo_ready_out <= fifo_in_ready & locked_r & powered;
    end
  end

  // sticky overflow: a word arrived with the buffer full; cleared by power-down
  always @(posedge ref_clk_in) begin
    if (rst_in || !powered) begin
      overflow_out <= 1'b0;
    end else if (push_req && !fifo_in_ready) begin
      overflow_out <= 1'b1;
    end
  end

  // buffer: mode is stored with each word, so a mode change never splits a frame
  dcbs_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clear_in(!powered),
    .in_valid_in(push_req),
    .in_ready_out(fifo_in_ready),
    .in_data_in({mode_s2_r, data_s2_r}), // high or open pin means balanced
    .out_valid_out(fifo_out_valid),
    .out_ready_in(load),
    .out_data_out(fifo_out_data)
  );

  // frame sequencer and forwarded clock shaping
  always @(posedge ref_clk_in) begin
    if (rst_in || !powered) begin
      busy_r <= 1'b0;
      bcnt_r <= `DCBS_BITCNT_ZERO;
      frame_bal_r <= 1'b1;
      clk_long_r <= 1'b0;
      ck_sh_r <= `DCBS_CLK_IDLE;
      frame_start_out <= 1'b0;
    end else begin
      frame_start_out <= load;
      if (load) begin
        busy_r <= 1'b1;
        bcnt_r <= `DCBS_BITCNT_ZERO;
        frame_bal_r <= word_bal;
        if (word_bal) begin
          // alternate 4/9 and 5/9 high; the clock sum swings by one
          ck_sh_r <= clk_long_r ? `DCBS_CLK_BAL_LONG : `DCBS_CLK_BAL_SHORT;
          clk_long_r <= ~clk_long_r;
        end else begin
          ck_sh_r <= `DCBS_CLK_PLAIN;
        end
      end else begin
        if (bit_last) begin
          busy_r <= 1'b0; // buffer empty: lanes idle low until the next word
        end
        bcnt_r <= bcnt_r + `DCBS_BITCNT_ONE;
        ck_sh_r <= {1'b0, ck_sh_r[`DCBS_FRAME_BITS-1:1]};
      end
    end
  end

  // three encoders, each fed its seven-bit slice
  genvar g;
  generate
    for (g = 0; g < `DCBS_LANES; g = g + 1) begin : g_lane
      dcbs_lane u_lane (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .clear_in(!powered),
        .load_in(load),
        .shift_in(busy_r),
        .balance_in(word_bal),
        .group_in(fifo_out_data[g*`DCBS_PAY_BITS +: `DCBS_PAY_BITS]),
        .bit_out(lane_bits[g])
      );
    end
  endgenerate
endmodule

// ### verif/dcbs_properties.sv
/*
  checker for the serializer top: power-down floating, lock bound,
  termination choice, frame shape and idle lanes.
  assumes it is bound to dcbs_serializer and sees only its ports.
*/
`timescale 1ns/100ps
`include "dcbs_defines.vh"
module dcbs_checker #(
  parameter LOCK_PERIODS = 8
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire parallel_clock_in,
  input wire power_down_n_in,
  input wire balance_mode_select_in,
  input wire [`DCBS_LANES-1:0] serial_lane_out,
  input wire serial_lane_oe_out,
  input wire forwarded_clock_out,
  input wire forwarded_clock_oe_out,
  input wire serial_valid_out,
  input wire frame_start_out,
  input wire pll_run_out,
  input wire term_enable_out,
  input wire term_high_out,
  input wire locked_out
);
  reg pc_d; // raw link clock one cycle back
  reg [16:0] rises; // raw link clock rises seen while locking
  // raw count runs a little ahead of the synced one, hence slack of two
  always @(posedge ref_clk_in) begin
    pc_d <= parallel_clock_in;
    if (rst_in || !pll_run_out || locked_out) begin
      rises <= 17'h00000;
    end else if (parallel_clock_in && !pc_d) begin
      rises <= rises + 17'h00001;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  // power-down may cut a frame short, so frame checks pause while the pin is low
  default disable iff (rst_in || !power_down_n_in);
  // first bits of the forwarded clock are high, bits five and six low
  sequence s_clk_shape;
    forwarded_clock_out [*4] ##2 !forwarded_clock_out [*2];
  endsequence
  sequence s_bits;
    serial_valid_out [*7];
  endsequence
  property p_float;
    disable iff (rst_in)
    !power_down_n_in [*6] |-> !serial_lane_oe_out && !pll_run_out && !term_enable_out;
  endproperty
  a_float: assert property (p_float) else $error("outputs driven in power-down");
  property p_oe_pair;
    serial_lane_oe_out == forwarded_clock_oe_out;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("lane and clock enables differ");
  property p_oe_lock;
    serial_lane_oe_out |-> locked_out;
  endproperty
  a_oe_lock: assert property (p_oe_lock) else $error("outputs driven before lock");
  property p_lock;
    rises <= LOCK_PERIODS + 2;
  endproperty
  a_lock: assert property (p_lock) else $error("lock took too many clock periods");
  property p_term_high;
    (power_down_n_in && !balance_mode_select_in) [*6] |-> term_high_out && term_enable_out;
  endproperty
  a_term_high: assert property (p_term_high) else $error("plain mode termination low");
  property p_bits;
    frame_start_out |-> s_bits;
  endproperty
  a_bits: assert property (p_bits) else $error("frame shorter than seven bits");
  property p_gap;
    frame_start_out |=> !frame_start_out [*6];
  endproperty
  a_gap: assert property (p_gap) else $error("frames start too close");
  property p_clk_shape;
    frame_start_out |-> s_clk_shape;
  endproperty
  a_clk_shape: assert property (p_clk_shape) else $error("forwarded clock shape wrong");
  property p_idle;
    !serial_valid_out |-> !forwarded_clock_out && serial_lane_out == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("lanes not low between frames");
endmodule
bind dcbs_serializer dcbs_checker #(.LOCK_PERIODS(LOCK_PERIODS)) u_chk (.ref_clk_in, .rst_in,
  .parallel_clock_in, .power_down_n_in, .balance_mode_select_in, .serial_lane_out,
  .serial_lane_oe_out, .forwarded_clock_out, .forwarded_clock_oe_out, .serial_valid_out,
  .frame_start_out, .pll_run_out, .term_enable_out, .term_high_out, .locked_out);

// ### verif/dcbs_rx_model.sv
/*
  far-end receiver model: collects lane frames, undoes inversion from the
  flags, tracks running sums and flags any coding fault.
  assumes a frame's first bit arrives with frame_start_out, then one bit per ref clock, lsb first.
*/
`timescale 1ns/100ps
module dcbs_rx_model (
  input wire clk_in,
  input wire clear_in,
  input wire bal_in,
  input wire [2:0] lane_in,
  input wire fclk_in,
  input wire valid_in,
  input wire start_in,
  output reg [20:0] word_out,
  output reg [2:0] inv_out,
  output reg [8:0] ck_out,
  output reg word_valid_out,
  output reg err_out
);
  reg [8:0] sh [0:2]; // frame being collected per lane
  reg [8:0] ck; // forwarded clock frame
  reg [3:0] cnt; // index the next bit takes
  reg [3:0] idx; // index of the bit on the lanes now
  integer rs [0:3]; // running sums, clock lane last
  integer l;
  // sums are kept per bit, so a mid-frame excursion is caught too;
  // a frame's first bit arrives together with start_in, so start forces index zero
  always @(posedge clk_in) begin
    word_valid_out <= 1'b0;
    idx = start_in ? 4'h0 : cnt;
    if (clear_in) begin
      cnt <= 4'h0;
      err_out <= 1'b0;
      for (l = 0; l < 4; l = l + 1) rs[l] = 0;
    end else begin
      if (valid_in) begin
        ck[idx] = fclk_in;
        for (l = 0; l < 4; l = l + 1) begin
          if (l < 3) sh[l][idx] = lane_in[l];
          rs[l] = rs[l] + (((l < 3) ? lane_in[l] : fclk_in) ? 1 : -1);
          if (bal_in && (rs[l] > ((l < 3) ? 10 : 5) || rs[l] < ((l < 3) ? -10 : -5)))
            err_out <= 1'b1;
        end
        if (idx == (bal_in ? 4'h8 : 4'h6)) begin
          word_valid_out <= 1'b1;
          ck_out <= ck;
          // flag one-zero means inverted, zero-one kept
          for (l = 0; l < 3; l = l + 1) begin
            inv_out[l] <= bal_in & sh[l][7];
            word_out[7*l +: 7] <= sh[l][6:0] ^ {7{bal_in & sh[l][7]}};
            if (bal_in && sh[l][7] == sh[l][8]) err_out <= 1'b1;
          end
        end
      end
      if (valid_in) cnt <= idx + 4'h1;
    end
  end
endmodule

// ### verif/dcbs_serializer_tb.sv
/*
  testbench for the serializer: plain and balanced framing, lane mapping,
  inversion order, lock sequence, buffer overflow and drain.
  assumes the receiver model and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
`include "dcbs_defines.vh"
module dcbs_serializer_tb;
  localparam LOCK = 8; // shortened lock count
  reg ref_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg pclk = 1'b0; // link clock, 200 ns
  reg pclk_en = 1'b0;
  reg pd_n = 1'b0;
  reg mode = 1'b1;
  reg [20:0] data = 21'h000000;
  wire [2:0] lanes, rx_inv;
  wire [20:0] rx_word;
  wire [8:0] rx_ck;
  wire oe, ck_oe, fclk, valid, start, pll, t_en, t_hi, locked, ovf, rdy, rx_valid, rx_err;
  integer bad_count = 0;
  integer comparisons = 0;
  integer n, early, i;
  dcbs_serializer #(.LOCK_PERIODS(LOCK)) u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .parallel_clock_in(pclk), .parallel_data_in(data), .power_down_n_in(pd_n),
    .balance_mode_select_in(mode), .serial_lane_out(lanes), .serial_lane_oe_out(oe),
    .forwarded_clock_out(fclk), .forwarded_clock_oe_out(ck_oe), .serial_valid_out(valid),
    .frame_start_out(start), .pll_run_out(pll), .term_enable_out(t_en),
    .term_high_out(t_hi), .locked_out(locked), .overflow_out(ovf), .fifo_ready_out(rdy));
  // undriven lanes show the inverse so a floating line never looks valid
  dcbs_rx_model u_rx (.clk_in(ref_clk_in), .clear_in(rst_in | ~pd_n), .bal_in(mode),
    .lane_in(oe ? lanes : ~lanes), .fclk_in(fclk), .valid_in(valid), .start_in(start),
    .word_out(rx_word), .inv_out(rx_inv), .ck_out(rx_ck), .word_valid_out(rx_valid),
    .err_out(rx_err));
  always #12.5 ref_clk_in = ~ref_clk_in;
  // link clock toggles while enabled and is held low otherwise, offset from the ref clock
  // its period stands for the frequency windows scaled to the ref-clock bit rate
  initial begin
    #3;
    forever #100 pclk = pclk_en & ~pclk;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // a wait that used up its cycles is a mismatch and ends the run at once
  task limit_hit(input integer lim);
    begin
      if (n >= lim) begin
        bad_count = bad_count + 1;
        end_of_test;
      end
    end
  endtask
  // power down, then release with mode and data and wait for lock
  task relock(input m, input [20:0] d);
    begin
      @(negedge ref_clk_in) pd_n = 1'b0;
      repeat (8) @(negedge ref_clk_in);
      check({oe, pll, t_en, ovf}, 0);
      mode = m;
      data = d;
      pclk_en = 1'b1;
      pd_n = 1'b1;
      n = 0;
      early = 0;
      while (locked !== 1'b1 && n < 2000) begin
        @(negedge ref_clk_in) n = n + 1;
        // enables rise with the lock flag, so only an enable before it counts
        if (oe !== 1'b0 && locked !== 1'b1) early = early + 1;
      end
      limit_hit(2000);
      check(n < (LOCK + 4) * 8, 1);
      check(early, 0);
      repeat (3) @(negedge ref_clk_in);
      check({oe, t_en, t_hi}, {2'h3, ~m});
    end
  endtask
  task get_word;
    begin
      n = 0;
      do begin
        @(negedge ref_clk_in) n = n + 1;
      end while (rx_valid !== 1'b1 && n < 1000);
      limit_hit(1000);
    end
  endtask
  // plain framing: seven raw bits, lanes fed by bits 0-6, 7-13, 14-20
  task t_plain;
    begin
      relock(1'b0, 21'h00602A);
      repeat (3) get_word;
      check(rx_word, 21'h00602A);
      check({rx_inv, rx_ck[6:0]}, 10'h00F);
    end
  endtask
  // balanced: inversion alternates from a zero sum, clock 4/9 then 5/9
  task t_bal;
    begin
      relock(1'b1, 21'h1FC055);
      for (i = 0; i < 4; i = i + 1) begin
        get_word;
        check(rx_word, 21'h1FC055);
        check(rx_inv, i[0] ? 3'h7 : 3'h0);
        check(rx_ck, i[0] ? 9'h01F : 9'h00F);
      end
      check(rx_err, 0);
    end
  endtask
  // the link clock outruns nine-bit frames until the buffer refuses
  task t_fill;
    begin
      n = 0;
      while (ovf !== 1'b1 && n < 6000) @(negedge ref_clk_in) n = n + 1;
      limit_hit(6000);
      check({ovf, rdy}, 2'h2);
      pclk_en = 1'b0;
      n = 0;
      while (valid !== 1'b0 && n < 2000) @(negedge ref_clk_in) n = n + 1;
      limit_hit(2000);
      @(negedge ref_clk_in);
      check({valid, rdy, rx_err}, 3'h2);
    end
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_in);
    rst_in = 1'b0;
    t_plain;
    t_bal;
    t_fill;
    t_plain;
    end_of_test;
  end
endmodule
